// File: lsr_pkg.sv
/*
 Package for the light sensor readout register bank: offsets, field
 positions, reset values and gain encodings.
 Assumes an 8-bit register port driven by a serial-bus front end on CLK.
*/
package lsr_pkg;
   // Register offsets
   localparam logic [7:0] OFS_GAIN_SELECT = 8'h0F;
   localparam logic [7:0] OFS_PART_ID = 8'h12;
   localparam logic [7:0] OFS_STATUS = 8'h13;
   localparam logic [7:0] OFS_BB_LOW = 8'h14;
   localparam logic [7:0] OFS_BB_HIGH = 8'h15;
   localparam logic [7:0] OFS_IR_LOW = 8'h16;
   localparam logic [7:0] OFS_IR_HIGH = 8'h17;
   // Field positions
   localparam int GAIN_LSB = 0;
   localparam int STAT_INT_BIT = 4;
   localparam int STAT_VALID_BIT = 0;
   // Reset values
   localparam logic [7:0] RST_GAIN_SELECT = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_RESULT = 16'h0000;
   // Part identification, value arbitrary
   localparam logic [7:0] PART_ID_VALUE = 8'hA5;
   // Gain codes
   typedef enum logic [1:0] {
      LSR_GAIN_X1, LSR_GAIN_X8, LSR_GAIN_X16, LSR_GAIN_X120
   } lsr_gain_e;
endpackage

// File: lsr_result_store.sv
/*
 Holds the latest 16-bit results of both channels, refreshed when an
 integration cycle ends. Read data comes out of a register.
 Assumes the integration engine pulses the done strobe for one cycle.
*/
module lsr_result_store (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // New results
   input wire logic done,
   input wire logic [15:0] bb_in,
   input wire logic [15:0] ir_in,
   // Read side
   input wire logic sel_ir,
   output logic [15:0] rd_word
);
   import lsr_pkg::*;
   logic [15:0] bb_ff;
   logic [15:0] ir_ff;
   // Store both channels on completion
   always_ff @(posedge clk) begin
      if (rst) begin
         bb_ff <= RST_RESULT;
         ir_ff <= RST_RESULT;
      end else if (done) begin
         bb_ff <= bb_in;
         ir_ff <= ir_in;
      end
   end
   // Registered read port; tracks the stored value one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_word <= RST_RESULT;
      end else begin
         rd_word <= sel_ir ? ir_ff : bb_ff;
      end
   end
endmodule

// File: lsr_regs.sv
/*
 Light sensor readout register bank: gain select, part identification,
 status and the four channel result bytes with per-channel shadowing.
 Register map, one byte each:
   0x0F gain_select, read/write, bits 1:0 pick the analogue gain
   0x12 part_identification, read only, fixed value
   0x13 sensor_status, read only, bit 4 interrupt, bit 0 valid
   0x14 broadband_result_low, 0x15 broadband_result_high
   0x16 infrared_result_low, 0x17 infrared_result_high
   Any other address reads zero and ignores writes.
 Reads answer two cycles after the strobe with a one-cycle valid pulse;
 read data then holds until the next answer. Writes give no answer.
 A low-byte read copies that channel's high byte into its own shadow.
 The gain code output follows a write two cycles after its strobe.
 Results and shadows reset to zero.
 Assumes a bus front end on CLK giving one-cycle read and write strobes
 with an 8-bit address, never both in one cycle; the integration engine
 is on the same clock and pulses its done strobe with both results valid.
 Assumes the front end spaces a high-byte read at least two cycles after
 the low-byte read of the same channel, as a serial bus always does.
*/
// Functional notes
// - The two-bit gain field in gain_select bits 1:0 drives the analogue gain code 1x/8x/16x/120x.
// - part_identification returns a fixed value and ignores writes.
// - sensor_status is read only and reads zero in bits 7:5 and 3:1.
// - Status bit 4 follows the light interrupt being asserted.
// - Status bit 0 sets once both channels finish an integration after enable.
// - Results appear as four bytes at 0x14..0x17, broadband low/high then infrared low/high.
// - A low-byte read captures that channel's upper byte into a shadow read by the high byte.
// - The high-byte read returns the shadow even if new integrations complete meanwhile.
module lsr_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   // Integration engine
   input wire logic LIGHT_SENSING_ENABLE,
   input wire logic INTEG_DONE,
   input wire logic [15:0] BROADBAND_RESULT,
   input wire logic [15:0] INFRARED_RESULT,
   input wire logic LIGHT_INTERRUPT,
   // Analogue gain
   output lsr_pkg::lsr_gain_e LIGHT_GAIN_CODE
);
   import lsr_pkg::*;

   // Address match shared by hit_gain, hit_bb_low and hit_ir_low
   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // Status byte; everything but the two flags reads zero
   function automatic logic [7:0] status_of(input logic intr, input logic vld);
      logic [7:0] s;
      s = RST_BYTE;
      s[STAT_INT_BIT] = intr;
      s[STAT_VALID_BIT] = vld;
      return s;
   endfunction

   // Byte for every address that is not a low result byte
   function automatic logic [7:0] pick_byte(
      input logic [7:0] addr,
      input logic [7:0] gain,
      input logic [7:0] stat,
      input logic [7:0] sh_bb,
      input logic [7:0] sh_ir
   );
      logic [7:0] b;
      case (addr)
         OFS_GAIN_SELECT: b = gain;
         OFS_PART_ID: b = PART_ID_VALUE;
         OFS_STATUS: b = stat;
         OFS_BB_HIGH: b = sh_bb;
         OFS_IR_HIGH: b = sh_ir;
         default: b = RST_BYTE;
      endcase
      return b;
   endfunction

   // Register state
   logic [7:0] gain_ff;
   logic valid_ff;
   logic int_ff;
   logic [7:0] shadow_bb_ff;
   logic [7:0] shadow_ir_ff;
   logic rd_pend_ff;
   logic cap_bb_ff;
   logic cap_ir_ff;
   logic [7:0] early_rdata_ff;
   // Combinational read select and the store's registered read word
   logic [7:0] nxt_rdata;
   logic [15:0] live_word;

   // Address decode, named wires for the gain and the two low result bytes only
   wire hit_gain = addr_is(REG_ADDR, OFS_GAIN_SELECT);
   wire hit_bb_low = addr_is(REG_ADDR, OFS_BB_LOW);
   wire hit_ir_low = addr_is(REG_ADDR, OFS_IR_LOW);
   wire wr_gain = REG_WR && hit_gain;
   wire rd_bb_low = REG_RD && hit_bb_low;
   wire rd_ir_low = REG_RD && hit_ir_low;
   wire sel_ir = hit_ir_low; // Infrared word only for its low byte

   // Status byte and every byte but the low result bytes, chosen by address
   wire [7:0] status_byte = status_of(int_ff, valid_ff);
   wire [7:0] early_byte = pick_byte(REG_ADDR, gain_ff, status_byte,
      shadow_bb_ff, shadow_ir_ff);
   wire [1:0] gain_field = gain_ff[GAIN_LSB +: 2];

   // Stored channel results
   lsr_result_store u_store (
      .clk(CLK),
      .rst(SYS_RST),
      .done(INTEG_DONE),
      .bb_in(BROADBAND_RESULT),
      .ir_in(INFRARED_RESULT),
      .sel_ir(sel_ir),
      .rd_word(live_word)
   );

   // Gain register; only the gain address is writable
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         gain_ff <= RST_GAIN_SELECT;
      end else if (wr_gain) begin
         gain_ff <= REG_WDATA; // Upper bits kept as written
      end
   end

   // Gain drive to the analogue block
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         LIGHT_GAIN_CODE <= LSR_GAIN_X1;
      end else begin
         LIGHT_GAIN_CODE <= lsr_gain_e'(gain_field);
      end
   end

   // Interrupt flag, one cycle behind the engine's level
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         int_ff <= 1'b0;
      end else begin
         int_ff <= LIGHT_INTERRUPT;
      end
   end

   // Valid flag; dropping the enable wins over a completion
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         valid_ff <= 1'b0;
      end else if (!LIGHT_SENSING_ENABLE) begin
         valid_ff <= 1'b0;
      end else if (INTEG_DONE) begin
         valid_ff <= 1'b1;
      end
   end

   // Read pipeline: result store answers one cycle after the strobe
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rd_pend_ff <= 1'b0;
         cap_bb_ff <= 1'b0;
         cap_ir_ff <= 1'b0;
         early_rdata_ff <= RST_BYTE;
      end else begin
         rd_pend_ff <= REG_RD;
         cap_bb_ff <= rd_bb_low;
         cap_ir_ff <= rd_ir_low;
         early_rdata_ff <= early_byte;
      end
   end

   // Shadow capture on low-byte reads, one per channel
   wire cap_bb = cap_bb_ff;
   wire cap_ir = cap_ir_ff;
   wire [7:0] live_low = live_word[7:0];
   wire [7:0] live_high = live_word[15:8];
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         shadow_bb_ff <= RST_BYTE;
         shadow_ir_ff <= RST_BYTE;
      end else begin
         if (cap_bb) begin
            shadow_bb_ff <= live_high;
         end
         if (cap_ir) begin
            shadow_ir_ff <= live_high;
         end
      end
   end

   // Read data select; high bytes come from shadows only
   assign nxt_rdata = (cap_bb || cap_ir) ? live_low : early_rdata_ff;

   // Answer data, held until the next read completes
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         REG_RDATA <= RST_BYTE;
      end else if (rd_pend_ff) begin
         REG_RDATA <= nxt_rdata;
      end
   end

   // Answer strobe, one cycle per read
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= rd_pend_ff;
      end
   end
endmodule

// File: lsr_chk_checker.sv
/* Port checker for lsr_regs.
 Assumes one clock domain, reset high. */
module lsr_chk import lsr_pkg::*; (
   // Watched ports
   input wire logic CLK, SYS_RST, REG_WR, REG_RD, REG_RVALID,
   input wire logic LIGHT_SENSING_ENABLE, LIGHT_INTERRUPT,
   input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
   input wire lsr_pkg::lsr_gain_e LIGHT_GAIN_CODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // Decoded requests
   wire logic wr_g = REG_WR && REG_ADDR == OFS_GAIN_SELECT;
   wire logic rd_st = REG_RD && REG_ADDR == OFS_STATUS;
   a_read_answer: assert property (REG_RD |-> ##2 REG_RVALID)
      else $error("late answer");
   a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD, 2))
      else $error("stray answer");
   a_data_hold: assert property (!REG_RVALID |-> $stable(REG_RDATA))
      else $error("data moved");
   a_gain_write: assert property (wr_g |-> ##2 LIGHT_GAIN_CODE == $past(REG_WDATA[1:0], 2))
      else $error("gain wrong");
   a_gain_hold: assert property ($changed(LIGHT_GAIN_CODE) |-> $past(wr_g, 2))
      else $error("gain moved");
   a_id_fixed: assert property (REG_RD && REG_ADDR == OFS_PART_ID |-> ##2 REG_RDATA == PART_ID_VALUE)
      else $error("id wrong");
   a_status_zeros: assert property (rd_st |-> ##2 (REG_RDATA & 8'hEE) == 8'h00)
      else $error("status reserved set");
   a_int_flag: assert property ((LIGHT_INTERRUPT && !SYS_RST)[*3] ##0 rd_st |-> ##2 REG_RDATA[4])
      else $error("int flag low");
   a_valid_off: assert property ((!LIGHT_SENSING_ENABLE)[*3] ##0 rd_st ##1 !LIGHT_SENSING_ENABLE
      |-> ##1 !REG_RDATA[0])
      else $error("valid set");
   c_status: cover property (rd_st);
   c_gain: cover property (wr_g);
   c_high: cover property (REG_RD && REG_ADDR == OFS_IR_HIGH);
endmodule
bind lsr_regs lsr_chk chk_u (.CLK, .SYS_RST, .REG_WR, .REG_RD, .REG_RVALID, .LIGHT_SENSING_ENABLE,
   .LIGHT_INTERRUPT, .REG_ADDR, .REG_WDATA, .REG_RDATA, .LIGHT_GAIN_CODE);

// File: lsr_engine_model.sv
/* Integration engine stand-in: done one cycle after a kick.
 Assumes the bench kicks it. */
module lsr_engine_model (
   // Clock and command
   input wire logic clk,
   input wire logic kick,
   // Results toward the device
   output logic done = 1'b0,
   output logic [15:0] bb,
   output logic [15:0] ir
);
   // Results churn every cycle, valid only with done
   always @(posedge clk) begin
      done <= kick;
      bb <= 16'($urandom);
      ir <= 16'($urandom);
   end
endmodule

// File: light_sensor_readout_registers_bench.sv
/* Bench for lsr_regs against a reference copy.
 Assumes lsr_engine_model supplies results. */
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module light_sensor_readout_registers_bench import lsr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, EN = 0, INTR = 0, kick = 0, done;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
   logic REG_RVALID;
   logic [15:0] bb, ir;
   lsr_gain_e gain;
   int fails = 0, check_count = 0, vld = 0, res[2] = '{0, 0}, sh[2] = '{0, 0};
   initial forever #10 CLK = ~CLK;
   lsr_regs dut_u (.CLK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
      .REG_RVALID, .LIGHT_SENSING_ENABLE(EN), .INTEG_DONE(done), .BROADBAND_RESULT(bb),
      .INFRARED_RESULT(ir), .LIGHT_INTERRUPT(INTR), .LIGHT_GAIN_CODE(gain));
   lsr_engine_model eng_u (.clk(CLK), .kick, .done, .bb, .ir);
   // Reference results and valid flag
   always @(posedge CLK) begin
      if (done === 1'b1) res = '{bb, ir};
      if (EN === 1'b0) vld = 0;
      else if (done === 1'b1) vld = 1;
   end
   task automatic cyc(int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] v);
      REG_WR <= 1; REG_ADDR <= a; REG_WDATA <= v;
      @(posedge CLK) REG_WR <= 0;
   endtask
   task automatic rd(logic [7:0] a, int e);
      REG_RD <= 1; REG_ADDR <= a;
      @(posedge CLK) REG_RD <= 0;
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK);
         if (REG_RVALID === 1'b1) begin `CHK(REG_RDATA, e[7:0]) return; end
      end
      fails++;
      test_done();
   endtask
   task automatic pulse();
      kick <= 1; cyc(1); kick <= 0; cyc(3);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(90));
      cyc(4);
      SYS_RST <= 0;
      rd(OFS_STATUS, 0);
      rd(OFS_BB_HIGH, 0);
      rd(8'h00, 0);
      wr(OFS_PART_ID, 8'($urandom));
      rd(OFS_PART_ID, PART_ID_VALUE);
      for (int g = 0; g < 4; g++) begin
         wr(OFS_GAIN_SELECT, 8'(g));
         cyc(3);
         `CHK(gain, g[1:0])
         rd(OFS_GAIN_SELECT, g);
      end
      EN <= 1; INTR <= 1; pulse();
      rd(OFS_STATUS, 16 + vld);
      EN <= 0; INTR <= 0; cyc(3);
      rd(OFS_STATUS, vld);
      EN <= 1;
      repeat (6) for (int c = 0; c < 2; c++) begin
         pulse();
         rd(OFS_BB_LOW + 8'(2 * c), res[c] & 255);
         sh[c] = res[c] >> 8;
         pulse();
         rd(OFS_BB_HIGH + 8'(2 * c), sh[c]);
         rd(OFS_BB_HIGH + 8'(2 - 2 * c), sh[1 - c]);
      end
      test_done();
   end
endmodule
